// ### include/serial_port_pkg.sv
// Shared constants and types of the three-wire serial register port
package serial_port_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS    = 10;
  localparam int SCLK_MAX_KHZ     = 20000;
  localparam int SCLK_MIN_CYCLES  = (1000000 / SCLK_MAX_KHZ + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRAP_MIN_NS     = 50;
  localparam int STRAP_MIN_CYCLES = (STRAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int ADDR_W    = 5;
  localparam int BYTE_W    = 8;
  localparam int REG_COUNT = 32;
  localparam int PIN_W     = 4;

  typedef logic [ADDR_W-1:0] reg_addr_t;
  typedef logic [BYTE_W-1:0] reg_byte_t;

  // Instruction byte, bit 7 down to bit 0
  typedef struct packed {
    logic      rw;
    logic [1:0] byte_count;
    reg_addr_t start_addr;
  } instr_t;

  // Synchronised port pins, bit 0 is the serial clock
  typedef struct packed {
    logic strap;
    logic sdio;
    logic cs_n;
    logic sclk;
  } pins_t;
  localparam logic [PIN_W-1:0] PIN_IDLE = 4'h2;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_INSTR = 4'h2,
    ST_DATA  = 4'h4,
    ST_DONE  = 4'h8
  } port_state_t;

  // ****************************************
  // Register map
  // ****************************************
  localparam reg_addr_t CFG_ADDR       = 5'h00;
  localparam reg_addr_t PWR_ADDR       = 5'h01;
  localparam reg_addr_t DATA_CTL_ADDR  = 5'h02;
  localparam reg_addr_t MEM_DATA_ADDR  = 5'h11;
  localparam reg_addr_t VERSION_ADDR   = 5'h1f;
  localparam int        BIT_ORDER_POS  = 6;
  localparam int        SOFT_RESET_POS = 5;

  localparam reg_byte_t CFG_RESET      = 8'h00;
  localparam reg_byte_t PWR_RESET      = 8'h40;
  localparam reg_byte_t DATA_CTL_RESET = 8'h34;
  localparam reg_byte_t MEM_DATA_RESET = 8'h3f;
  localparam reg_byte_t OTHER_RESET    = 8'h00;

  function automatic reg_byte_t reg_default(reg_addr_t a);
    case (a)
      CFG_ADDR:      reg_default = CFG_RESET;
      PWR_ADDR:      reg_default = PWR_RESET;
      DATA_CTL_ADDR: reg_default = DATA_CTL_RESET;
      MEM_DATA_ADDR: reg_default = MEM_DATA_RESET;
      default:       reg_default = OTHER_RESET;
    endcase
  endfunction

endpackage

// ### rtl/three_wire_serial_register_port.sv
// Three-wire serial register port: instruction byte, then one to four data bytes
module three_wire_serial_register_port #(
  parameter logic [7:0] VERSION_CODE = 8'h5a // Arbitrary identification value
) (
  input  wire logic                                        clk,                  // System clock
  input  wire logic                                        sys_rst,              // Sync reset
  input  wire logic                                        sclk,                 // Serial clock pin
  input  wire logic                                        cs_n,                 // Select, low
  input  wire logic                                        sdio_in,              // Data pin level
  input  wire logic                                        reset_or_strap_input, // Reset pin
  output logic                                             sdio_out,             // Data drive
  output logic                                             sdio_oe,              // Data enable
  output logic [serial_port_pkg::REG_COUNT*serial_port_pkg::BYTE_W-1:0] cfg_regs, // Reg image
  output logic                                             reg_write_pulse,      // Byte written
  output serial_port_pkg::reg_addr_t                       reg_write_addr,       // Its address
  output serial_port_pkg::port_state_t                     port_state            // Port phase
);
  import serial_port_pkg::*;

  // ****************************************
  // Pin synchronisers and filters
  // ****************************************
  logic [PIN_W-1:0] sync1_reg;
  logic [PIN_W-1:0] sync2_reg;
  logic [PIN_W-1:0] sync3_reg;
  logic [PIN_W-1:0] filt_reg;
  pins_t            pin;
  logic             sclk_prev_reg;
  logic             sclk_rise;
  logic             sclk_fall;
  logic             port_reset;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_reg <= PIN_IDLE;
      sync2_reg <= PIN_IDLE;
      sync3_reg <= PIN_IDLE;
    end else begin
      sync1_reg <= {reset_or_strap_input, sdio_in, cs_n, sclk};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // A level only counts once two later stages agree, which drops one-cycle glitches
  genvar b;
  generate
    for (b = 0; b < PIN_W; b++) begin : g_filt
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          filt_reg[b] <= PIN_IDLE[b];
        end else if (sync2_reg[b] == sync3_reg[b]) begin
          filt_reg[b] <= sync3_reg[b];
        end
      end
    end
  endgenerate

  assign pin = filt_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= pin.sclk;
    end
  end

  // Data is filtered in step with the clock, so it is still centred at the edge
  assign sclk_rise  = pin.sclk & ~sclk_prev_reg;
  assign sclk_fall  = ~pin.sclk & sclk_prev_reg;
  assign port_reset = sys_rst | pin.strap;

  // ****************************************
  // Shift path and address stepping
  // ****************************************
  reg_byte_t   regfile_reg [REG_COUNT];
  port_state_t state_reg;
  instr_t      instr_reg;
  reg_byte_t   shift_reg;
  reg_byte_t   tx_reg;
  logic [2:0]  bit_cnt_reg;
  logic [1:0]  bytes_left_reg;
  reg_addr_t   addr_reg;
  reg_byte_t   shift_in;
  instr_t      instr_next;
  logic        lsb_first;
  logic        order_after;
  logic        byte_done;
  logic        wr_now;
  logic        soft_reset_hit;
  reg_addr_t   step_addr;
  logic        instr_done;
  logic        data_byte_done;

  assign lsb_first = regfile_reg[CFG_ADDR][BIT_ORDER_POS];

  always_comb begin
    if (lsb_first) begin
      shift_in = {pin.sdio, shift_reg[7:1]};
    end else begin
      shift_in = {shift_reg[6:0], pin.sdio};
    end
  end

  assign instr_next     = instr_t'(shift_in);
  assign byte_done      = sclk_rise && (bit_cnt_reg == 3'd7);
  // Select high wins over a byte that completes in the same cycle
  assign instr_done     = !pin.cs_n && byte_done
                          && (state_reg == ST_IDLE || state_reg == ST_INSTR);
  assign data_byte_done = !pin.cs_n && byte_done && (state_reg == ST_DATA);
  assign wr_now         = data_byte_done && !instr_reg.rw;
  assign soft_reset_hit = wr_now && (addr_reg == CFG_ADDR) && shift_in[SOFT_RESET_POS];

  // A byte that rewrites the bit order already steers the step after it
  assign order_after = (wr_now && addr_reg == CFG_ADDR) ? shift_in[BIT_ORDER_POS]
                                                        : lsb_first;

  always_comb begin
    if (order_after) begin
      step_addr = addr_reg + 5'h01;
    end else begin
      step_addr = addr_reg - 5'h01;
    end
  end

  // ****************************************
  // Port state machine
  // ****************************************
  always_ff @(posedge clk) begin
    if (port_reset || pin.cs_n) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE, ST_INSTR: begin
          if (instr_done) begin
            state_reg <= ST_DATA;
          end else begin
            state_reg <= ST_INSTR;
          end
        end
        ST_DATA: begin
          if (data_byte_done && bytes_left_reg == 2'd0) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          // Clocks past the encoded count are ignored until select rises
          state_reg <= ST_DONE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Bits keep counting through both phases; the state alone says what a byte means
  always_ff @(posedge clk) begin
    if (port_reset || pin.cs_n) begin
      bit_cnt_reg <= 3'd0;
    end else if (sclk_rise && state_reg != ST_DONE) begin
      bit_cnt_reg <= bit_cnt_reg + 3'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (port_reset) begin
      shift_reg <= '0;
    end else if (!pin.cs_n && sclk_rise && state_reg != ST_DONE) begin
      shift_reg <= shift_in;
    end
  end

  // ****************************************
  // Instruction, address and byte count
  // ****************************************
  always_ff @(posedge clk) begin
    if (port_reset) begin
      instr_reg      <= '0;
      addr_reg       <= '0;
      bytes_left_reg <= 2'd0;
    end else if (instr_done) begin
      instr_reg      <= instr_next;
      addr_reg       <= instr_next.start_addr;
      bytes_left_reg <= instr_next.byte_count;
    end else if (data_byte_done) begin
      addr_reg <= step_addr;
      if (bytes_left_reg != 2'd0) begin
        bytes_left_reg <= bytes_left_reg - 2'd1;
      end
    end
  end

  // Reads show the register as it stood when its byte began, not as it ends
  always_ff @(posedge clk) begin
    if (port_reset) begin
      tx_reg <= '0;
    end else if (instr_done) begin
      tx_reg <= regfile_reg[instr_next.start_addr];
    end else if (data_byte_done) begin
      tx_reg <= regfile_reg[step_addr];
    end
  end

  assign port_state = state_reg;

  // ****************************************
  // Register file
  // ****************************************
  // Partial bytes never reach this array: writes happen only on a completed byte
  genvar i;
  generate
    for (i = 0; i < REG_COUNT; i++) begin : g_reg
      localparam reg_addr_t ADDR_I = reg_addr_t'(i);
      if (i == int'(VERSION_ADDR)) begin : g_ro
        always_ff @(posedge clk) begin
          regfile_reg[i] <= VERSION_CODE;
        end
      end else if (i == int'(CFG_ADDR)) begin : g_cfg
        always_ff @(posedge clk) begin
          if (port_reset) begin
            regfile_reg[i] <= reg_default(ADDR_I);
          end else if (wr_now && addr_reg == ADDR_I) begin
            // Soft reset bit self-clears so a later read shows zero
            regfile_reg[i] <= shift_in & ~(8'h01 << SOFT_RESET_POS);
          end
        end
      end else begin : g_rw
        always_ff @(posedge clk) begin
          if (port_reset || soft_reset_hit) begin
            regfile_reg[i] <= reg_default(ADDR_I);
          end else if (wr_now && addr_reg == ADDR_I) begin
            regfile_reg[i] <= shift_in;
          end
        end
      end
      assign cfg_regs[i*BYTE_W +: BYTE_W] = regfile_reg[i];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (port_reset) begin
      reg_write_pulse <= 1'b0;
      reg_write_addr  <= '0;
    end else begin
      reg_write_pulse <= wr_now;
      if (wr_now) begin
        reg_write_addr <= addr_reg;
      end
    end
  end

  // ****************************************
  // Read data driver
  // ****************************************
  always_ff @(posedge clk) begin
    if (port_reset || pin.cs_n) begin
      sdio_oe <= 1'b0;
    end else if (state_reg == ST_DATA && instr_reg.rw && sclk_fall) begin
      sdio_oe <= 1'b1;
    end else if (state_reg != ST_DATA) begin
      sdio_oe <= 1'b0;
    end
  end

  // The bit leaves a few system clocks after the pin falls, well before the
  // host's next rising edge; faster serial clocks would eat into that margin
  always_ff @(posedge clk) begin
    if (port_reset || pin.cs_n) begin
      sdio_out <= 1'b0;
    end else if (state_reg == ST_DATA && instr_reg.rw && sclk_fall) begin
      if (lsb_first) begin
        sdio_out <= tx_reg[bit_cnt_reg];
      end else begin
        sdio_out <= tx_reg[3'd7 - bit_cnt_reg];
      end
    end
  end

endmodule

// ### dv/serial_port_sva.sv
// Concurrent checks on the serial register port pins
module serial_port_sva (
  input wire logic                            clk,                  // Clock
  input wire logic                            sys_rst,              // Reset
  input wire logic                            sclk,                 // Serial clock
  input wire logic                            cs_n,                 // Select
  input wire logic                            sdio_in,              // Wire
  input wire logic                            reset_or_strap_input, // Strap
  input wire logic                            sdio_out,             // Drive
  input wire logic                            sdio_oe,              // Enable
  input wire logic [serial_port_pkg::REG_COUNT*serial_port_pkg::BYTE_W-1:0] cfg_regs, // Regs
  input wire logic                            reg_write_pulse,      // Written
  input wire serial_port_pkg::reg_addr_t      reg_write_addr,       // Address
  input wire serial_port_pkg::port_state_t    port_state            // Phase
);
  timeunit 1ns;
  timeprecision 100ps;
  import serial_port_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_strap_held;
    reset_or_strap_input [*6];
  endsequence
  sequence s_desel;
    cs_n [*8];
  endsequence
  a_desel_release: assert property (s_desel |-> !sdio_oe)
    else $error("data line driven while deselected");
  a_strap_idle: assert property (s_strap_held |-> port_state == ST_IDLE)
    else $error("strap did not return port to start");
  a_strap_nowrite: assert property (reset_or_strap_input [*6] |-> !reg_write_pulse)
    else $error("register written under strap");
  a_pulse_one: assert property (reg_write_pulse |=> !reg_write_pulse)
    else $error("write pulse longer than one cycle");
  a_write_quiet: assert property (reg_write_pulse |-> !sdio_oe)
    else $error("data line driven in a write");
  a_instr_quiet: assert property (port_state == ST_INSTR |-> !sdio_oe)
    else $error("data line driven in instruction phase");
  a_out_hold: assert property ($rose(sclk) && sdio_oe |=> $stable(sdio_out) [*3])
    else $error("read bit changed near rising edge");
  a_ver_fixed: assert property (1'b1 |-> $stable(cfg_regs[255:248]))
    else $error("read-only register changed");
endmodule

bind three_wire_serial_register_port serial_port_sva i_serial_port_sva (
  .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
  .reset_or_strap_input(reset_or_strap_input), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
  .cfg_regs(cfg_regs), .reg_write_pulse(reg_write_pulse), .reg_write_addr(reg_write_addr),
  .port_state(port_state));

// ### dv/serial_host.sv
// Host model: serial master driving clock, select, data and strap
module serial_host (
  input  wire logic clk,  // Clock
  input  wire logic sdio, // Wire level
  input  wire logic lsb,  // Bit order
  output logic      sclk, // Serial clock
  output logic      cs_n, // Select
  output logic      hdat, // Data drive
  output logic      hoe,  // Data enable
  output logic      strap // Strap pin
);
  timeunit 1ns;
  timeprecision 100ps;
  event       rdy;
  logic [7:0] rbyte;
  initial {sclk, cs_n, hdat, hoe, strap} = 5'h08;
  // Halves of 80 ns keep the serial clock at 6.25 MHz
  task automatic half();
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic strap_pulse(); // 60 ns high, then low
    @(posedge clk);
    #1;
    strap = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    strap = 1'b0;
  endtask
  // Stops after cut bits to model an early select rise
  task automatic frame(input logic [7:0] ins, input int n, input int cut, input logic [31:0] wd);
    int j;
    half();
    cs_n = 1'b0;
    for (int k = 0; k < 8 * n + 8 && k < cut; k++) begin
      j = lsb ? k % 8 : 7 - k % 8;
      hdat = k < 8 ? ins[j] : wd[8 * (k / 8 - 1) + j]; // Changed at the fall
      hoe = k < 8 || !ins[7];
      half();
      sclk = 1'b1;
      if (k >= 8 && ins[7]) begin
        rbyte[j] = sdio;
        if (k % 8 == 7) -> rdy;
      end
      half();
      sclk = 1'b0;
    end
    hoe = 1'b0;
    half();
    cs_n = 1'b1;
  endtask
endmodule

// ### dv/three_wire_serial_register_port_tb.sv
// Self-checking bench of the three-wire serial register port
module three_wire_serial_register_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import serial_port_pkg::*;
  localparam logic [7:0] VER = 8'h5a; // Arbitrary identification value
  logic        clk = 0, sys_rst = 1, sdio_last = 0, lsb = 0;
  logic        sdio_out, sdio_oe, reg_write_pulse;
  logic [255:0] cfg_regs;
  logic [31:0] w;
  reg_addr_t   reg_write_addr;
  port_state_t port_state;
  wire         sclk, cs_n, hdat, hoe, strap;
  wire         sdio = sdio_oe ? sdio_out : hoe ? hdat : ~sdio_last; // No pull on the wire
  reg_byte_t   mem [32];
  logic [12:0] wq [$];
  reg_byte_t   rq [$];
  int          fails = 0, checks_done = 0;
  integer      seed = 32'hf9054b7a;
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (sdio_oe || hoe) sdio_last <= sdio;
  three_wire_serial_register_port #(.VERSION_CODE(VER)) i_three_wire_serial_register_port (
    .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio),
    .reset_or_strap_input(strap), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .cfg_regs(cfg_regs),
    .reg_write_pulse(reg_write_pulse), .reg_write_addr(reg_write_addr), .port_state(port_state));
  serial_host i_serial_host (.clk(clk), .sdio(sdio), .lsb(lsb), .sclk(sclk), .cs_n(cs_n),
    .hdat(hdat), .hoe(hoe), .strap(strap));
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic init(input logic all);
    for (int a = 0; a < 32; a++)
      if (all || a != 0) mem[a] = a == 1 ? 8'h40 : a == 2 ? 8'h34 : a == 17 ? 8'h3f :
                                  a == 31 ? VER : 8'h00;
  endtask
  // Notes the expected bytes, then runs the frame; bytes cut short are not expected
  task automatic xfer(input logic rw, input int n, input reg_addr_t a, input logic [31:0] wd,
                      input int cut);
    reg_addr_t p;
    p = a;
    for (int i = 0; i < n; i++) begin
      if (cut >= 8 * i + 16 && rw) rq.push_back(mem[p]);
      if (cut >= 8 * i + 16 && !rw) begin
        mem[p] = wd[8 * i +: 8];
        wq.push_back({p, wd[8 * i +: 8]});
      end
      p = lsb ? p + 5'h01 : p - 5'h01;
    end
    i_serial_host.frame({rw, 2'(n - 1), a}, n, cut, wd);
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Register zero reads back with its soft reset bit already cleared
  task automatic check_write(input logic [12:0] e);
    reg_byte_t x;
    x = e[12:8] == CFG_ADDR ? e[7:0] & ~(8'h01 << SOFT_RESET_POS) : e[7:0];
    cmp("write address", 8'(e[12:8]), 8'(reg_write_addr));
    cmp("write data", x, cfg_regs[8 * e[12:8] +: 8]);
  endtask
  task automatic check_read(input reg_byte_t exp);
    cmp("read data", exp, i_serial_host.rbyte);
  endtask
  always @(posedge clk)
    if (reg_write_pulse === 1'b1)
      check_write(wq.size() > 0 ? wq.pop_front() : 13'h1fff);
  always @(i_serial_host.rdy) check_read(rq.pop_front());
  initial begin
    #300000;
    fails++;
    conclude();
  end
  initial begin
    init(1'b1);
    repeat (16) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    repeat (8) @(posedge clk);
    w = $random(seed);
    xfer(1'b1, 4, 5'h02, 0, 99); // Defaults, wrap past zero
    xfer(1'b0, 4, 5'h0a, w, 99);
    xfer(1'b1, 4, 5'h0a, 0, 99);
    xfer(1'b0, 2, 5'h05, ~w, 19); // Select rises in the second byte
    xfer(1'b1, 2, 5'h05, 0, 99);
    fork
      xfer(1'b0, 1, 5'h06, w, 14);
      begin
        repeat (160) @(posedge clk);
        i_serial_host.strap_pulse();
      end
    join
    init(1'b1);
    xfer(1'b1, 4, 5'h07, 0, 99);
    xfer(1'b0, 1, 5'h00, 8'h40, 99);
    lsb = 1'b1;
    w = $random(seed);
    xfer(1'b0, 2, 5'h1c, w, 99);
    xfer(1'b1, 2, 5'h1c, 0, 99);
    xfer(1'b0, 1, 5'h00, 8'h60, 99);
    init(1'b0);
    mem[0] = 8'h40;
    xfer(1'b1, 2, 5'h1c, 0, 99);
    xfer(1'b1, 1, 5'h00, 0, 99);
    repeat (20) @(posedge clk);
    cmp("pending notes", 8'h00, 8'(wq.size() + rq.size()));
    conclude();
  end
endmodule
